//--- inc/fmr_pkg.sv
// fault mask, status word and readback register group: shared constants
// assumes a 16-bit serial frame: address, write flag, data, odd parity
`default_nettype none
package fmr_pkg;
	// ******************************************
	// frame layout
	// ******************************************
	localparam int          WORD_W     = 16;
	localparam int          ADDR_LSB   = 11;
	localparam int          WR_BIT     = 10;
	localparam logic [4:0]  FRAME_BITS = 5'h10;
	localparam logic [4:0]  CNT_MAX    = 5'h1f;
	// ******************************************
	// register addresses
	// ******************************************
	localparam logic [4:0]  ADDR_MASK   = 5'h1c;
	localparam logic [4:0]  ADDR_RBSEL  = 5'h1d;
	localparam logic [4:0]  ADDR_DEMAND = 5'h1e;
	localparam logic [4:0]  ADDR_RBDATA = 5'h1f;
	// ******************************************
	// field positions
	// ******************************************
	localparam int          MASK_LSB = 1;
	localparam int          DGS_LSB  = 8;
	localparam int          DSR_BIT  = 7;
	localparam int          LBR_BIT  = 5;
	localparam int          CKS_BIT  = 4;
	localparam int          RBS_LSB  = 1;
	localparam int          DEM_LSB  = 1;
	localparam logic [9:0]  CURLIM_OR = 10'h01f;
	localparam logic        POR_RST   = 1'h1;
	// sync chain reset equals idle pins: select high, sck low, no false edge
	localparam logic [2:0]  SYNC_RST  = 3'h4;
	// ******************************************
	// codes
	// ******************************************
	localparam logic [1:0]  DGS_FLAG   = 2'h0;
	localparam logic [1:0]  DGS_TACHO  = 2'h1;
	localparam logic [1:0]  DGS_PULSE  = 2'h2;
	localparam logic [1:0]  DGS_PTACHO = 2'h3;
	localparam logic [1:0]  CM_CURRENT = 2'h2;
	localparam logic [1:0]  CM_OPEN    = 2'h3;
	localparam logic [2:0]  RBS_FAULT_OUTPUT_PIN   = 3'h0;
	localparam logic [2:0]  RBS_SPEED  = 3'h1;
	localparam logic [2:0]  RBS_CURR   = 3'h2;
	localparam logic [2:0]  RBS_VOLT   = 3'h3;
	localparam logic [2:0]  RBS_TEMP   = 3'h4;
	localparam logic [2:0]  RBS_DEMAND = 3'h5;
	localparam logic [2:0]  RBS_DUTY   = 3'h6;
	localparam logic [2:0]  RBS_ADV    = 3'h7;

	typedef enum logic {FMR_IDLE, FMR_SHIFT} fmr_state_e;

	// maskable sources: watchdog .. drain-source, msb first
	typedef struct packed {
		logic [8:0] maskable;
		logic       pump_undervolt;
		logic       current_limit_hit;
	} fmr_flt_s;

	typedef struct packed {
		logic       speed_overrange;
		logic [2:0] boot_fault;
		logic [5:0] vds_fault;
		logic [9:0] speed;
		logic [9:0] supply_current;
		logic [9:0] supply_volt;
		logic [9:0] chip_temp;
		logic [9:0] peak_duty;
		logic [9:0] phase_adv;
	} fmr_meas_s;

	typedef struct packed {
		logic [1:0] fault_output_pin_pin_select;
		logic       read_clear_dis;
		logic       lin_rate_select;
		logic       sdo_idle_select;
		logic [2:0] readback_source;
	} fmr_cfg_s;
endpackage
`default_nettype wire

//--- core/fmr_clk_div.sv
// free running divider producing a square wave
// assumes the system clock; half period is HALF cycles
`default_nettype none
module fmr_clk_div #(
	parameter int unsigned W    = 8,
	parameter int unsigned HALF = 4
) (
	input  wire logic i_clk_sys,
	input  wire logic i_arst_n,
	output logic      o_clk_div
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic         out_r;
	logic         out_nxt;

	always_comb begin
		cnt_nxt = cnt_r + W'(1);
		out_nxt = out_r;
		if (cnt_r == W'(HALF - 1)) begin
			cnt_nxt = '0;
			out_nxt = ~out_r;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_r <= '0;
			out_r <= 1'h0;
		end else begin
			cnt_r <= cnt_nxt;
			out_r <= out_nxt;
		end
	end

	assign o_clk_div = out_r;
endmodule
`default_nettype wire

//--- core/fmr_regs.sv
// serial-reached fault mask, status word, readback select, demand, readback
// assumes serial pins from the host and fault/measure inputs on i_clk_sys
//
// Contract
// - mask bit 1 disables that fault's detection, 0 permits it
// - status word holds one latched bit per fault source
// - summary flag is any status fault except current limit hit
// - after reset summary and power-up flags read 1, others 0
// - fault_output_pin pin selector picks fault flag, tacho, pulse or pulsed tacho
// - serial read clears fault bits unless read-clear-disable is set
// - lin rate select chooses 10 kHz at 0, 20 kHz at 1
// - idle sdo is high impedance or divided clock per idle select
// - three-bit readback source selects readback register content
// - current mode uses demand ored with 0x01f
// - open-loop mode uses demand as bridge peak duty
// - peak duty goes to sine generator or straight to bridge
// - source 0 returns overrange, bootstrap and drain-source bits
// - source 1 returns the ten speed bits, overrange only under source 0
// - speed readback stays valid during forward windmill
// - source 2 returns average supply current code
// - source 3 returns supply voltage code
// - source 4 returns chip temperature code
// - source 5 returns last written demand
// - source 6 returns applied bridge peak duty
// - source 7 returns applied phase advance code
// - control mode: 0,1 speed, 2 current, 3 open loop
`default_nettype none
module fmr_regs #(
	parameter int unsigned SDO_DIV_HALF   = 4,
	parameter int unsigned PULSE_DIV_HALF = 128
) (
	input  wire logic              i_clk_sys,
	input  wire logic              i_arst_n,
	input  wire logic              i_serial_select_n,
	input  wire logic              i_sck,
	input  wire logic              i_sdi,
	output logic                   o_sdo,
	output logic                   o_sdo_oe_n,
	input  wire fmr_pkg::fmr_flt_s  i_flt,
	input  wire fmr_pkg::fmr_meas_s i_meas,
	input  wire logic              i_tacho_signal,
	input  wire logic [1:0]        i_control_mode_sel,
	output logic [8:0]             o_fault_mask,
	output logic [15:0]            o_status_word,
	output logic                   o_fault_output_pin,
	output logic                   o_lin_rate_select,
	output logic [9:0]             o_demand_value,
	output logic [9:0]             o_current_limit_code,
	output logic [9:0]             o_peak_duty_cmd,
	output logic                   o_open_loop_active
);
	// ******************************************
	// helpers
	// ******************************************
	function automatic logic [15:0] with_par(input logic [15:1] w);
		with_par = {w, ~^w};
	endfunction

	// ******************************************
	// pin synchronisers
	// ******************************************
	logic [2:0] s1_r, s2_r, s3_r;
	logic [2:0] s1_nxt, s2_nxt, s3_nxt;
	always_comb begin
		s1_nxt = {i_serial_select_n, i_sck, i_sdi};
		s2_nxt = s1_r;
		s3_nxt = s2_r;
	end
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s1_r <= fmr_pkg::SYNC_RST;
			s2_r <= fmr_pkg::SYNC_RST;
			s3_r <= fmr_pkg::SYNC_RST;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
		end
	end
	logic sel_n, sdi, sel_fall, sel_rise, sck_rise, sck_fall;
	assign sel_n    = s2_r[2];
	assign sdi      = s2_r[0];
	assign sel_fall = s3_r[2] & ~s2_r[2];
	assign sel_rise = ~s3_r[2] & s2_r[2];
	assign sck_rise = ~s3_r[1] & s2_r[1];
	assign sck_fall = s3_r[1] & ~s2_r[1];

	// ******************************************
	// frame engine
	// ******************************************
	fmr_pkg::fmr_state_e state_r, state_nxt;
	logic [4:0]  cnt_r, cnt_nxt;
	logic [15:0] rx_r, rx_nxt, tx_r, tx_nxt, pend_w_r, pend_w_nxt;
	logic        pend_r, pend_nxt, ans_st_r, ans_st_nxt;
	logic        done, done_ok, done_bad, wr;
	logic [4:0]  addr;
	logic [15:0] status_w;
	logic [9:0]  rb_val;
	fmr_pkg::fmr_cfg_s cfg_r, cfg_nxt;
	logic [8:0]  mask_r, mask_nxt;

	assign addr     = rx_r[fmr_pkg::ADDR_LSB +: 5];
	assign wr       = rx_r[fmr_pkg::WR_BIT];
	assign done     = (state_r == fmr_pkg::FMR_SHIFT) & sel_rise;
	assign done_ok  = done & (cnt_r == fmr_pkg::FRAME_BITS) & (^rx_r);
	assign done_bad = done & ~done_ok;

	always_comb begin
		state_nxt  = state_r;
		cnt_nxt    = cnt_r;
		rx_nxt     = rx_r;
		tx_nxt     = tx_r;
		pend_nxt   = pend_r;
		pend_w_nxt = pend_w_r;
		ans_st_nxt = ans_st_r;
		unique case (state_r)
			fmr_pkg::FMR_IDLE: begin
				if (sel_fall) begin
					state_nxt  = fmr_pkg::FMR_SHIFT;
					cnt_nxt    = '0;
					tx_nxt     = pend_r ? pend_w_r : status_w;
					ans_st_nxt = ~pend_r;
					pend_nxt   = 1'h0;
				end
			end
			fmr_pkg::FMR_SHIFT: begin
				if (sck_rise) begin
					rx_nxt = {rx_r[14:0], sdi};
					if (cnt_r != fmr_pkg::CNT_MAX)
						cnt_nxt = cnt_r + 5'h01;
				end
				if (sck_fall)
					tx_nxt = {tx_r[14:0], 1'h0};
				if (sel_rise) begin
					state_nxt = fmr_pkg::FMR_IDLE;
					// a read frame answers in the next frame
					if (done_ok && !wr) begin
						pend_nxt = 1'h1;
						unique case (addr)
							fmr_pkg::ADDR_MASK:
								pend_w_nxt = with_par({addr, 1'h0, mask_r});
							fmr_pkg::ADDR_RBSEL:
								pend_w_nxt = with_par({addr, 1'h0,
									cfg_r.fault_output_pin_pin_select,
									cfg_r.read_clear_dis, 1'h0,
									cfg_r.lin_rate_select,
									cfg_r.sdo_idle_select,
									cfg_r.readback_source});
							fmr_pkg::ADDR_RBDATA:
								pend_w_nxt = with_par({addr, rb_val});
							default:
								pend_nxt = 1'h0;
						endcase
					end
				end
			end
		endcase
	end
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_r  <= fmr_pkg::FMR_IDLE;
			cnt_r    <= '0;
			rx_r     <= '0;
			tx_r     <= '0;
			pend_r   <= 1'h0;
			pend_w_r <= '0;
			ans_st_r <= 1'h1;
		end else begin
			state_r  <= state_nxt;
			cnt_r    <= cnt_nxt;
			rx_r     <= rx_nxt;
			tx_r     <= tx_nxt;
			pend_r   <= pend_nxt;
			pend_w_r <= pend_w_nxt;
			ans_st_r <= ans_st_nxt;
		end
	end

	// ******************************************
	// configuration registers
	// ******************************************
	logic [9:0] demand_r, demand_nxt;
	always_comb begin
		mask_nxt   = mask_r;
		cfg_nxt    = cfg_r;
		demand_nxt = demand_r;
		if (done_ok) begin
			if (wr && addr == fmr_pkg::ADDR_MASK)
				mask_nxt = rx_r[fmr_pkg::MASK_LSB +: 9];
			if (wr && addr == fmr_pkg::ADDR_RBSEL) begin
				cfg_nxt.fault_output_pin_pin_select = rx_r[fmr_pkg::DGS_LSB +: 2];
				cfg_nxt.read_clear_dis  = rx_r[fmr_pkg::DSR_BIT];
				cfg_nxt.lin_rate_select = rx_r[fmr_pkg::LBR_BIT];
				cfg_nxt.sdo_idle_select = rx_r[fmr_pkg::CKS_BIT];
				cfg_nxt.readback_source = rx_r[fmr_pkg::RBS_LSB +: 3];
			end
			if (addr == fmr_pkg::ADDR_DEMAND)
				demand_nxt = rx_r[fmr_pkg::DEM_LSB +: 10];
		end
	end
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mask_r   <= '0;
			cfg_r    <= '0;
			demand_r <= '0;
		end else begin
			mask_r   <= mask_nxt;
			cfg_r    <= cfg_nxt;
			demand_r <= demand_nxt;
		end
	end

	// ******************************************
	// status latches
	// ******************************************
	logic [11:0] st_r, st_nxt, st_set;
	logic        por_r, por_nxt, clr, ff;
	logic [8:0]  flt_det;
	assign flt_det = i_flt.maskable & ~mask_r;
	assign st_set  = {done_bad, i_flt.pump_undervolt,
		i_flt.current_limit_hit, flt_det};
	// only a completed status answer clears
	assign clr = done_ok & ans_st_r & ~cfg_r.read_clear_dis;
	always_comb begin
		st_nxt  = (st_r & ~{12{clr}}) | st_set;
		por_nxt = por_r & ~clr;
	end
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_r  <= '0;
			por_r <= fmr_pkg::POR_RST;
		end else begin
			st_r  <= st_nxt;
			por_r <= por_nxt;
		end
	end
	// current limit kept out of summary
	assign ff = por_r | st_r[11] | st_r[10] | (|st_r[8:0]);
	assign status_w = with_par({ff, por_r, st_r[11:9], 1'h0, st_r[8:0]});

	// ******************************************
	// readback mux and demand use
	// ******************************************
	always_comb begin
		unique case (cfg_r.readback_source)
			fmr_pkg::RBS_FAULT_OUTPUT_PIN: rb_val = {i_meas.speed_overrange,
				i_meas.boot_fault, i_meas.vds_fault};
			fmr_pkg::RBS_SPEED:  rb_val = i_meas.speed;
			fmr_pkg::RBS_CURR:   rb_val = i_meas.supply_current;
			fmr_pkg::RBS_VOLT:   rb_val = i_meas.supply_volt;
			fmr_pkg::RBS_TEMP:   rb_val = i_meas.chip_temp;
			fmr_pkg::RBS_DEMAND: rb_val = demand_r;
			fmr_pkg::RBS_DUTY:   rb_val = i_meas.peak_duty;
			fmr_pkg::RBS_ADV:    rb_val = i_meas.phase_adv;
		endcase
	end

	logic [9:0] curlim_r, duty_r;
	logic       open_r;
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			curlim_r <= fmr_pkg::CURLIM_OR;
			duty_r   <= '0;
			open_r   <= 1'h0;
		end else begin
			curlim_r <= demand_r | fmr_pkg::CURLIM_OR;
			open_r   <= (i_control_mode_sel == fmr_pkg::CM_OPEN);
			duty_r   <= demand_r;
		end
	end
	// ******************************************
	// pins
	// ******************************************
	logic sdo_clk, pulse;
	fmr_clk_div #(.W(8), .HALF(SDO_DIV_HALF)) u_sdo_div (
		.i_clk_sys (i_clk_sys),
		.i_arst_n  (i_arst_n),
		.o_clk_div (sdo_clk)
	);
	fmr_clk_div #(.W(8), .HALF(PULSE_DIV_HALF)) u_pulse_div (
		.i_clk_sys (i_clk_sys),
		.i_arst_n  (i_arst_n),
		.o_clk_div (pulse)
	);
	logic sdo_r, sdo_nxt, oe_n_r, oe_n_nxt, pin_r, pin_nxt;
	always_comb begin
		if (state_r == fmr_pkg::FMR_SHIFT) begin
			sdo_nxt  = tx_r[15];
			oe_n_nxt = 1'h0;
		end else begin
			sdo_nxt  = cfg_r.sdo_idle_select & sdo_clk;
			oe_n_nxt = ~cfg_r.sdo_idle_select;
		end
		unique case (cfg_r.fault_output_pin_pin_select)
			fmr_pkg::DGS_FLAG:   pin_nxt = ~ff;
			fmr_pkg::DGS_TACHO:  pin_nxt = i_tacho_signal;
			fmr_pkg::DGS_PULSE:  pin_nxt = ~ff & pulse;
			fmr_pkg::DGS_PTACHO: pin_nxt = ~ff & i_tacho_signal;
		endcase
	end
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sdo_r  <= 1'h0;
			oe_n_r <= 1'h1;
			pin_r  <= 1'h0;
		end else begin
			sdo_r  <= sdo_nxt;
			oe_n_r <= oe_n_nxt;
			pin_r  <= pin_nxt;
		end
	end

	assign o_sdo                = sdo_r;
	assign o_sdo_oe_n           = oe_n_r;
	assign o_fault_output_pin   = pin_r;
	assign o_fault_mask         = mask_r;
	assign o_status_word        = status_w;
	// baud rate choice to lin interface
	assign o_lin_rate_select    = cfg_r.lin_rate_select;
	assign o_demand_value       = demand_r;
	assign o_current_limit_code = curlim_r;
	assign o_peak_duty_cmd      = duty_r;
	assign o_open_loop_active   = open_r;

	// ******************************************
	// checks
	// ******************************************
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);

	a_mask_gate_det: assert property (
		(mask_r[0] && !st_r[0]) |=> !st_r[0])
		else $error("masked fault latched");
	a_status_latch: assert property (
		flt_det[8] |=> st_r[8] && o_status_word[9])
		else $error("fault not latched");
	a_summary_excl: assert property (
		(o_status_word[11] && !(|o_status_word[14:12])
			&& !(|o_status_word[9:1])) |-> !o_status_word[15])
		else $error("current limit drove summary");
	a_por_hold: assert property (
		(por_r && !clr) |=> por_r && o_status_word[15])
		else $error("power-up flag lost");
	a_fault_output_pin_flag: assert property (
		(cfg_r.fault_output_pin_pin_select == fmr_pkg::DGS_FLAG) ##1
		(cfg_r.fault_output_pin_pin_select == fmr_pkg::DGS_FLAG)
		|-> o_fault_output_pin == !$past(ff))
		else $error("fault_output_pin pin not fault flag");
	a_read_keep: assert property (
		(cfg_r.read_clear_dis && st_r[8]) |=> st_r[8])
		else $error("read cleared with clear disabled");
	a_lin_write: assert property (
		(done_ok && wr && addr == fmr_pkg::ADDR_RBSEL)
		|=> o_lin_rate_select == $past(rx_r[fmr_pkg::LBR_BIT]))
		else $error("lin rate not written");
	a_sdo_idle_hiz: assert property (
		(sel_n && state_r == fmr_pkg::FMR_IDLE
			&& !cfg_r.sdo_idle_select) |=> o_sdo_oe_n)
		else $error("sdo driven while idle");
	a_rb_demand: assert property (
		(done_ok && !wr && addr == fmr_pkg::ADDR_RBDATA
			&& cfg_r.readback_source == fmr_pkg::RBS_DEMAND)
		|=> pend_w_r[10:1] == $past(demand_r))
		else $error("demand echo wrong");
	a_curlim_or: assert property (
		$stable(demand_r) [*2] |-> o_current_limit_code
			== (demand_r | fmr_pkg::CURLIM_OR))
		else $error("current limit code wrong");
	a_ro_ignore: assert property (
		(done_ok && addr == fmr_pkg::ADDR_RBDATA)
		|=> $stable(cfg_r) && $stable(mask_r) && $stable(demand_r))
		else $error("readback write changed state");

	c_good_frame: cover property (done_ok);
	c_bad_frame: cover property (done_bad);
	c_read_pend: cover property (done_ok && !wr ##[1:300] pend_r);
	c_read_clear: cover property (clr && st_r[8]);
endmodule
`default_nettype wire

//--- verif/fmr_host_model.sv
// host end of the serial link: frames msb first, up to 16 bits
// assumes the device takes sdi on sck rise and moves sdo after sck fall
`default_nettype none
module fmr_host_model (
	input  wire logic i_clk_sys,
	input  wire logic i_sdo,
	output logic      o_serial_select_n,
	output logic      o_sck,
	output logic      o_sdi
);
	timeunit 1ns;
	timeprecision 1ps;
	// **********
	// idle pins
	// **********
	// sck stands low between frames
	initial begin
		o_serial_select_n = 1'b1;
		o_sck = 1'b0;
		o_sdi = 1'b0;
	end
	// **********
	// one frame, pins move only after falling clock edges
	// **********
	task automatic xfer(input int nb, input logic [15:0] tx,
		output logic [15:0] rx);
		rx = '0;
		o_serial_select_n = 1'b0;
		repeat (2) @(negedge i_clk_sys);
		for (int i = 0; i < nb; i++) begin
			o_sdi = tx[15 - i];
			// long low phase so the synchronised sdo bit has settled
			repeat (6) @(negedge i_clk_sys);
			o_sck = 1'b1;
			rx = {rx[14:0], i_sdo};
			repeat (4) @(negedge i_clk_sys);
			o_sck = 1'b0;
		end
		repeat (6) @(negedge i_clk_sys);
		o_serial_select_n = 1'b1;
		// released data line shows the inverse, never a stale bit
		o_sdi = ~o_sdi;
		repeat (12) @(negedge i_clk_sys);
	endtask
endmodule
`default_nettype wire

//--- verif/fmr_regs_tb_top.sv
// bench for the fault mask, status word and readback register group
// assumes fmr_pkg, fmr_regs and fmr_host_model are compiled before it
`default_nettype none
module fmr_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic               i_clk_sys, i_arst_n, sel_n, sck, sdi, sdo, oe_n;
	logic               tacho, fault_output_pin, lin, open_o, m_dsr, m_lbr, m_cks, m_rd;
	logic [1:0]         cm, m_dgs;
	logic [2:0]         m_rbs;
	logic [4:0]         m_last;
	logic [8:0]         mask_o, m_mask;
	logic [9:0]         dem_o, clim_o, duty_o, m_dem;
	logic [13:0]        m_st;
	logic [15:0]        rx, rv, st_o;
	logic [31:0]        seed;
	fmr_pkg::fmr_flt_s  flt;
	fmr_pkg::fmr_meas_s meas;
	wire logic          sdo_pin;
	int                 fail_count, cmp_count, n_a, n_b;
	// **********
	// design and host
	// **********
	assign sdo_pin = oe_n ? 1'bz : sdo;
	initial begin
		i_clk_sys = 1'b0;
		forever #2 i_clk_sys = ~i_clk_sys;
	end
	// short dividers keep the pulse and idle clock checks brief
	fmr_regs #(.SDO_DIV_HALF(2), .PULSE_DIV_HALF(4)) dut_u (
		.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
		.i_serial_select_n(sel_n), .i_sck(sck), .i_sdi(sdi),
		.o_sdo(sdo), .o_sdo_oe_n(oe_n), .i_flt(flt), .i_meas(meas),
		.i_tacho_signal(tacho), .i_control_mode_sel(cm),
		.o_fault_mask(mask_o), .o_status_word(st_o),
		.o_fault_output_pin(fault_output_pin), .o_lin_rate_select(lin),
		.o_demand_value(dem_o), .o_current_limit_code(clim_o),
		.o_peak_duty_cmd(duty_o), .o_open_loop_active(open_o));
	fmr_host_model host_u (.i_clk_sys(i_clk_sys), .i_sdo(sdo_pin),
		.o_serial_select_n(sel_n), .o_sck(sck), .o_sdi(sdi));
	// **********
	// model
	// **********
	function automatic logic ff();
		return |{m_st[13:11], m_st[8:0]};
	endfunction
	function automatic logic [15:0] par(input logic [14:0] p);
		return {p, ~^p};
	endfunction
	function automatic logic [15:0] rnd();
		repeat (16) seed = {seed[30:0], ^(seed & 32'h80200003)};
		return seed[15:0];
	endfunction
	function automatic logic [9:0] rb();
		case (m_rbs)
		3'h0: return {meas.speed_overrange, meas.boot_fault, meas.vds_fault};
		3'h1: return meas.speed;
		3'h2: return meas.supply_current;
		3'h3: return meas.supply_volt;
		3'h4: return meas.chip_temp;
		3'h5: return m_dem;
		3'h6: return meas.peak_duty;
		default: return meas.phase_adv;
		endcase
	endfunction
	// **********
	// checks
	// **********
	task automatic chk(input logic [39:0] got, input logic [39:0] exp,
		input string what);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what,
				got, exp);
		end
	endtask
	task automatic regs_chk();
		chk({mask_o, lin, dem_o, clim_o, duty_o},
			{m_mask, m_lbr, m_dem, m_dem | 10'h01f, m_dem}, "regs");
		chk(40'(st_o), 40'(par({ff(), m_st})), "status");
		if (m_dgs == 2'h0)
			chk(40'(fault_output_pin), 40'(!ff()), "fault_output_pin pin");
	endtask
	task automatic frame(input int nb, input logic [14:0] p, input logic bad);
		logic [15:0] ans;
		logic        clr;
		clr = !m_rd && !m_dsr;
		if (!m_rd)
			ans = par({ff(), m_st});
		else if (m_last == 5'h1c)
			ans = par({m_last, 1'b0, m_mask});
		else if (m_last == 5'h1d)
			ans = par({m_last, 1'b0, m_dgs, m_dsr, 1'b0, m_lbr, m_cks, m_rbs});
		else
			ans = par({m_last, rb()});
		host_u.xfer(nb, par(p) ^ {15'h0, bad}, rx);
		if (nb == 16)
			chk(
				40'(rx), 40'(ans), "answer");
		if (nb != 16 || bad) begin
			m_st[12] = 1'b1;
			m_rd = 1'b0;
		end else begin
			if (clr)
				m_st = '0;
			m_rd = !p[9] && p[14:10] != 5'h1e;
			m_last = p[14:10];
			if (p[14:10] == 5'h1e)
				m_dem = p[9:0];
			else if (p[9] && p[14:10] == 5'h1c)
				m_mask = p[8:0];
			else if (p[9] && p[14:10] == 5'h1d)
				{m_dgs, m_dsr, m_lbr, m_cks, m_rbs} = {p[8:6], p[4:0]};
		end
		regs_chk();
	endtask
	task automatic pulse(input logic [10:0] f);
		flt = f;
		repeat (3) @(negedge i_clk_sys);
		flt = '0;
		repeat (3) @(negedge i_clk_sys);
		m_st[11:10] = m_st[11:10] | f[1:0];
		m_st[8:0] = m_st[8:0] | (f[10:2] & ~m_mask);
		regs_chk();
	endtask
	// fault_output_pin high count; sdo toggles plus 64 per cycle with sdo released
	task automatic watch(output int na, output int nb);
		logic prev;
		na = 0;
		nb = 0;
		prev = sdo;
		repeat (32) begin
			@(negedge i_clk_sys);
			na += int'(fault_output_pin === 1'b1);
			nb += int'(sdo !== prev) + 64 * int'(oe_n === 1'b1);
			prev = sdo;
		end
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// **********
	// sequence
	// **********
	initial begin
		repeat (100000) @(posedge i_clk_sys);
		fail_count++;
		test_done();
	end
	initial begin
		i_arst_n = 1'b0;
		flt = '0;
		meas = '0;
		{tacho, cm, fail_count, cmp_count} = '0;
		{m_mask, m_dgs, m_dsr, m_lbr, m_cks, m_rbs, m_dem, m_rd, m_last} = '0;
		m_st = 14'h2000;
		seed = 32'h4f8c;
		repeat (16) @(negedge i_clk_sys);
		i_arst_n = 1'b1;
		repeat (4) @(negedge i_clk_sys);
		regs_chk();
		chk(40'({oe_n, open_o}), 40'(2'b10), "idle pins");
		$display("reset values done");
		frame(16, {5'h1c, 1'b0, 9'h0}, 1'b0);
		rv = rnd();
		frame(16, {5'h1c, 1'b1, rv[8:0]}, 1'b0);
		frame(16, {5'h1c, 1'b0, 9'h0}, 1'b0);
		rv = rnd();
		frame(16, {5'h1d, 1'b1, rv[8:0]}, 1'b0);
		frame(16, {5'h1d, 1'b0, 9'h0}, 1'b0);
		for (int i = 0; i < 3; i++) begin
			rv = (i == 0) ? 16'h03ff : rnd();
			frame(16, {5'h1e, rv[9:0]}, 1'b0);
		end
		$display("register access done");
		// meas only moves between a source change and its read
		for (int k = 0; k < 8; k++) begin
			frame(16, {5'h1d, 1'b1, 6'h0, k[2:0]}, 1'b0);
			meas = 70'({rnd(), rnd(), rnd(), rnd(), rnd()});
			frame(16, {5'h1f, 1'b0, 9'h0}, 1'b0);
		end
		$display("readback sources done");
		frame(16, {5'h1c, 1'b1, 9'h1aa}, 1'b0);
		pulse(11'h7ff);
		frame(16, {5'h1c, 1'b1, 9'h000}, 1'b0);
		pulse(11'h001);
		frame(16, {5'h1d, 1'b1, 9'h040}, 1'b0);
		pulse(11'h400);
		frame(16, {5'h1d, 1'b0, 9'h0}, 1'b0);
		frame(16, {5'h1d, 1'b1, 9'h0}, 1'b0);
		frame(16, {5'h1f, 1'b1, 9'h155}, 1'b0);
		$display("masking and clearing done");
		frame(16, {5'h1c, 1'b1, 9'h0ff}, 1'b1);
		frame(15, {5'h1e, 10'h2aa}, 1'b0);
		frame(16, {5'h1d, 1'b0, 9'h0}, 1'b0);
		$display("frame errors done");
		for (int c = 1; c < 4; c += 2) begin
			frame(16, {5'h1d, 1'b1, c[1:0], 7'h0}, 1'b0);
			for (int j = 0; j < 2; j++) begin
				tacho = j[0];
				repeat (4) @(negedge i_clk_sys);
				chk(40'(fault_output_pin), 40'(tacho), "tacho");
			end
		end
		pulse(11'h400);
		chk(40'(fault_output_pin), 40'(0), "faulted tacho");
		frame(16, {5'h1d, 1'b1, 9'h100}, 1'b0);
		watch(n_a, n_b);
		chk(40'(n_a > 0 && n_a < 32), 40'(1), "pulse");
		pulse(11'h400);
		watch(n_a, n_b);
		chk(40'(n_a), 40'(0), "faulted pulse");
		$display("fault_output_pin pin done");
		frame(16, {5'h1d, 1'b1, 9'h018}, 1'b0);
		watch(n_a, n_b);
		chk(40'(n_b), 40'(16), "idle clock");
		frame(16, {5'h1d, 1'b1, 9'h000}, 1'b0);
		watch(n_a, n_b);
		chk(40'(n_b >> 6), 40'(32), "idle released");
		$display("sdo idle done");
		for (int k = 0; k < 4; k++) begin
			cm = k[1:0];
			repeat (3) @(negedge i_clk_sys);
			chk(40'(open_o), 40'(k == 3), "open loop");
		end
		$display("control mode done");
		test_done();
	end
endmodule
`default_nettype wire
